// file: rtl/tptc_top.sv
// Summary of operation
// [RULE1] internal timing: cfg bit3 0 picks divided clock, 1 external pixel clock
// [RULE2] cfg bit2 0: timing comes from incoming pixel clock, DE, HS, VS
// [RULE3] cfg bit2 1: own timing from programmed totals, actives, widths, porches
// [RULE4] cfg bit1 inverts every pattern colour bit when set
// [RULE5] auto-scroll off: the selected pattern is held indefinitely
// [RULE6] auto-scroll on: step to next enabled pattern after hold frames
// [RULE7] 8-bit indirect address register, read/write, resets to zero
// [RULE8] software sets the indirect address before each data window access
// [RULE9] write to indirect data stores the byte at the indirect address
// [RULE10] read of indirect data returns the byte at the indirect address
// [RULE11] patterns appear only with master enable set; else video passes
// [RULE12] indirect space is 256 zero-reset bytes holding timing settings
//
// Register access over Avalon-MM was decided locally.
`include "tptc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tptc_top (
	input  wire logic             clk_i,            // 20 MHz clock
	input  wire logic             sys_rst_i,        // async reset, high
	input  wire logic [9:0]       avs_address_i,    // byte address
	input  wire logic             avs_read_i,       // read request
	input  wire logic             avs_write_i,      // write request
	input  wire logic [31:0]      avs_writedata_i,  // write data
	input  wire logic [3:0]       avs_byteenable_i, // byte lanes
	output logic      [31:0]      avs_readdata_o,   // read data
	output logic                  avs_waitrequest_o,// stall
	input  wire logic             ext_pclk_i,       // pixel clock pin
	input  wire tptc_pkg::tptc_vid_t vid_i,         // incoming video
	output tptc_pkg::tptc_vid_t   vid_o,            // video out
	output logic                  pattern_active_o, // insertion on
	output logic      [2:0]       current_pattern_o // shown pattern
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [11:0] get12(
		input logic [255:0][7:0] m,
		input logic [7:0]        lo
	);
		get12 = {m[8'(lo + 8'h01)][3:0], m[lo]};
	endfunction : get12

	function automatic logic [11:0] ext12(input logic [7:0] b);
		ext12 = {4'h0, b};
	endfunction : ext12

	function automatic logic [23:0] pattern_color(
		input logic [2:0]  p,
		input logic [11:0] x,
		input logic [11:0] y
	);
		unique case (p)
			3'h0: pattern_color = {{8{x[7]}}, {8{x[6]}}, {8{x[5]}}};
			3'h1: pattern_color = 24'hFFFFFF;
			3'h2: pattern_color = 24'h000000;
			3'h3: pattern_color = 24'hFF0000;
			3'h4: pattern_color = 24'h00FF00;
			3'h5: pattern_color = 24'h0000FF;
			3'h6: pattern_color = {3{x[7:0]}};
			3'h7: pattern_color = {24{x[0] ^ y[0]}};
		endcase
	endfunction : pattern_color

	function automatic logic [2:0] next_enabled(
		input logic [2:0] cur,
		input logic [7:0] mask
	);
		logic [2:0] c;
		logic       found;
		next_enabled = cur;
		found = 1'b0;
		for (int i = 1; i < 8; i++) begin
			c = 3'(cur + 3'(i));
			if (!found && mask[c]) begin
				next_enabled = c;
				found = 1'b1;
			end
		end
	endfunction : next_enabled

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	tptc_pkg::tptc_state_t r_reg;
	tptc_pkg::tptc_state_t r_next;
	logic                  req;
	logic                  take;
	logic [7:0]            idx;
	logic                  pix_en;
	logic                  div_tick;
	logic                  ext_edge;
	logic                  use_int;
	logic                  frame_start;
	logic [11:0]           htot;
	logic [11:0]           vtot;
	logic [11:0]           hstart;
	logic [11:0]           vstart;
	logic                  int_de;
	logic                  int_hs;
	logic                  int_vs;
	logic                  h_last;
	logic                  v_last;
	logic [7:0]            hold;
	tptc_pkg::tptc_vid_t   vin;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		// bus slave: one wait cycle, commit at the released edge
		req  = avs_read_i | avs_write_i;
		take = req & r_reg.ack;
		idx  = avs_address_i[9:2];
		r_next.ack = req & ~r_reg.ack;
		if (req && !r_reg.ack) begin
			unique case (idx)
				`TPTC_IDX_CTRL: r_next.rdata = {31'h0, r_reg.en};
				`TPTC_IDX_CFG:  r_next.rdata = {24'h0, r_reg.cfg};
				`TPTC_IDX_IA:   r_next.rdata = {24'h0, r_reg.ia}; // RULE7
				`TPTC_IDX_ID:   r_next.rdata = {24'h0,
					r_reg.mem[r_reg.ia]};                      // RULE10
				`TPTC_IDX_STAT: r_next.rdata = {25'h0, r_reg.pat,
					3'h0, r_reg.en};
				default:        r_next.rdata = 32'h0;
			endcase
		end
		if (take && avs_write_i && avs_byteenable_i[0]) begin
			unique case (idx)
				`TPTC_IDX_CTRL: r_next.en  =
					avs_writedata_i[`TPTC_CTRL_EN];
				`TPTC_IDX_CFG:  r_next.cfg = avs_writedata_i[7:0];
				`TPTC_IDX_IA:   r_next.ia  = avs_writedata_i[7:0]; // RULE7
				`TPTC_IDX_ID:   r_next.mem[r_reg.ia] =
					avs_writedata_i[7:0];                      // RULE9 RULE12
				default: ;
			endcase
		end

		// pin synchronisers
		r_next.s1     = {ext_pclk_i, vid_i};
		r_next.s2     = r_reg.s1;
		vin           = r_reg.s2.vid;
		r_next.pclk_d = r_reg.s2.pclk;
		ext_edge      = r_reg.s2.pclk & ~r_reg.pclk_d;

		// pixel rate selection
		div_tick   = (r_reg.div == `TPTC_DIV_LAST);
		r_next.div = div_tick ? 4'h0 : 4'(r_reg.div + 4'h1);
		use_int    = r_reg.cfg[`TPTC_CFG_TSEL];                // RULE2 RULE3
		pix_en     = (use_int && !r_reg.cfg[`TPTC_CFG_EXTCLK]) ?
			div_tick : ext_edge;                               // RULE1

		// internal frame timing from the indirect map
		htot   = get12(r_reg.mem, `TPTC_IND_HTOT_L);           // RULE3
		vtot   = get12(r_reg.mem, `TPTC_IND_VTOT_L);
		hstart = 12'(ext12(r_reg.mem[`TPTC_IND_HSW]) +
			ext12(r_reg.mem[`TPTC_IND_HBP]));
		vstart = 12'(ext12(r_reg.mem[`TPTC_IND_VSW]) +
			ext12(r_reg.mem[`TPTC_IND_VBP]));
		h_last = 12'(r_reg.h + 12'h001) >= htot;
		v_last = 12'(r_reg.v + 12'h001) >= vtot;
		int_hs = (r_reg.h < ext12(r_reg.mem[`TPTC_IND_HSW])) ^
			r_reg.mem[`TPTC_IND_SYNC][0];
		int_vs = (r_reg.v < ext12(r_reg.mem[`TPTC_IND_VSW])) ^
			r_reg.mem[`TPTC_IND_SYNC][1];
		int_de = (r_reg.h >= hstart) && (r_reg.v >= vstart) &&
			(r_reg.h < 12'(hstart +
				get12(r_reg.mem, `TPTC_IND_HACT_L))) &&
			(r_reg.v < 12'(vstart +
				get12(r_reg.mem, `TPTC_IND_VACT_L)));
		if (pix_en && use_int) begin                           // RULE3
			r_next.h = h_last ? 12'h000 : 12'(r_reg.h + 12'h001);
			if (h_last)
				r_next.v = v_last ? 12'h000 : 12'(r_reg.v + 12'h001);
		end
		if (use_int) begin
			r_next.x = 12'(r_reg.h - hstart);
			r_next.y = 12'(r_reg.v - vstart);
		end else if (pix_en) begin                             // RULE2
			r_next.x = vin.de ? 12'(r_reg.x + 12'h001) : 12'h000;
			if (r_reg.de_d && !vin.de)
				r_next.y = 12'(r_reg.y + 12'h001);
			if (vin.vs && !r_reg.vs_d)
				r_next.y = 12'h000;
		end
		if (pix_en) begin
			r_next.de_d = vin.de;
			r_next.vs_d = vin.vs;
		end
		frame_start = use_int ? (pix_en && h_last && v_last) :
			(pix_en && vin.vs && !r_reg.vs_d);

		// pattern selection and auto-scroll
		hold = (r_reg.mem[`TPTC_IND_HOLD] == 8'h00) ? 8'h01 :
			r_reg.mem[`TPTC_IND_HOLD];
		if (!r_reg.cfg[`TPTC_CFG_SCROLL]) begin
			r_next.pat    = r_reg.mem[`TPTC_IND_SEL][2:0];     // RULE5
			r_next.frames = 8'h00;
		end else if (frame_start) begin
			if (8'(r_reg.frames + 8'h01) >= hold) begin        // RULE6
				r_next.frames = 8'h00;
				r_next.pat    = next_enabled(r_reg.pat,
					r_reg.mem[`TPTC_IND_MASK]);
			end else begin
				r_next.frames = 8'(r_reg.frames + 8'h01);
			end
		end

		// output stage
		if (pix_en) begin
			if (!r_reg.en) begin
				r_next.out = vin;                              // RULE11
			end else begin
				r_next.out.de  = use_int ? int_de : vin.de;
				r_next.out.hs  = use_int ? int_hs : vin.hs;
				r_next.out.vs  = use_int ? int_vs : vin.vs;
				r_next.out.rgb = (use_int ? int_de : vin.de) ?
					(pattern_color(r_reg.pat, r_reg.x, r_reg.y) ^
					{24{r_reg.cfg[`TPTC_CFG_INV]}}) :          // RULE4
					24'h000000;
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			r_reg <= '0;                                       // RULE12
		end else begin
			r_reg <= r_next;
		end
	end

	assign avs_readdata_o    = r_reg.rdata;
	assign avs_waitrequest_o = req & ~r_reg.ack;
	assign vid_o             = r_reg.out;
	assign pattern_active_o  = r_reg.en;
	assign current_pattern_o = r_reg.pat;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	property p_ia_write;
		take && avs_write_i && avs_byteenable_i[0] && idx == `TPTC_IDX_IA
		|=> r_reg.ia == $past(avs_writedata_i[7:0]);
	endproperty
	a_ia_write: assert property (p_ia_write) // RULE7
		else $error("indirect address not stored");

	property p_id_write;
		take && avs_write_i && avs_byteenable_i[0] && idx == `TPTC_IDX_ID
		|=> r_reg.mem[r_reg.ia] == $past(avs_writedata_i[7:0]);
	endproperty
	a_id_write: assert property (p_id_write) // RULE9
		else $error("indirect data write missed its location");

	property p_id_read;
		take && avs_read_i && idx == `TPTC_IDX_ID
		|-> avs_readdata_o == {24'h0, r_reg.mem[r_reg.ia]};
	endproperty
	a_id_read: assert property (p_id_read) // RULE10
		else $error("indirect data read wrong");

	property p_div_clock;
		use_int && !r_reg.cfg[`TPTC_CFG_EXTCLK] && pix_en
		&& $stable(r_reg.cfg) |=> !pix_en;
	endproperty
	a_div_clock: assert property (p_div_clock) // RULE1
		else $error("divided clock not in use");

	property p_ext_timing;
		!use_int && r_reg.en && pix_en ##1 !$changed(r_reg.cfg)
		|-> vid_o.de == $past(vin.de);
	endproperty
	a_ext_timing: assert property (p_ext_timing) // RULE2
		else $error("external data enable not followed");

	property p_int_wrap;
		use_int && pix_en && h_last |=> r_reg.h == 12'h000;
	endproperty
	a_int_wrap: assert property (p_int_wrap) // RULE3
		else $error("line counter did not wrap");

	property p_invert;
		r_reg.en && r_reg.cfg[`TPTC_CFG_INV] && r_reg.pat == 3'h2
		&& pix_en && (use_int ? int_de : vin.de)
		|=> vid_o.rgb == 24'hFFFFFF;
	endproperty
	a_invert: assert property (p_invert) // RULE4
		else $error("inverted black is not white");

	property p_hold;
		!r_reg.cfg[`TPTC_CFG_SCROLL] ##1 !r_reg.cfg[`TPTC_CFG_SCROLL]
		|-> r_reg.pat == $past(r_reg.mem[`TPTC_IND_SEL][2:0]);
	endproperty
	a_hold: assert property (p_hold) // RULE5
		else $error("pattern moved without auto-scroll");

	property p_scroll_bound;
		r_reg.cfg[`TPTC_CFG_SCROLL] && !frame_start
		|=> r_reg.pat == $past(r_reg.pat);
	endproperty
	a_scroll_bound: assert property (p_scroll_bound) // RULE6
		else $error("pattern moved between frames");

	property p_pass;
		!r_reg.en && pix_en |=> vid_o == $past(vin);
	endproperty
	a_pass: assert property (p_pass) // RULE11
		else $error("video not passed while disabled");

	property p_ia_read;
		take && avs_read_i && idx == `TPTC_IDX_IA
		|-> avs_readdata_o == {24'h0, r_reg.ia};
	endproperty
	a_ia_read: assert property (p_ia_read) // RULE7
		else $error("indirect address read wrong");

	// divider ticks must not step the counters on the pixel clock
	property p_ext_clock;
		use_int && r_reg.cfg[`TPTC_CFG_EXTCLK] && !ext_edge
		|=> r_reg.h == $past(r_reg.h);
	endproperty
	a_ext_clock: assert property (p_ext_clock) // RULE1
		else $error("line counter moved without pixel clock");

	property p_int_hs;
		use_int && r_reg.en && pix_en |=> vid_o.hs == $past(int_hs);
	endproperty
	a_int_hs: assert property (p_int_hs) // RULE3
		else $error("internal line sync not driven");

	c_scroll:   cover property (r_reg.cfg[0] && frame_start
		##1 $changed(r_reg.pat));
	c_id_read:  cover property (take && avs_read_i
		&& idx == `TPTC_IDX_ID);
	c_int_frame: cover property (use_int && frame_start);
	c_ext_clock: cover property (use_int && r_reg.cfg[3]
		&& ext_edge);
	c_invert:   cover property (r_reg.en && r_reg.cfg[1] && vid_o.de);
endmodule : tptc_top
`default_nettype wire

// file: rtl/tptc_defines.svh
`ifndef TPTC_DEFINES_SVH
`define TPTC_DEFINES_SVH
// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define TPTC_IDX_CTRL    8'h64
`define TPTC_IDX_CFG     8'h65
`define TPTC_IDX_IA      8'h66
`define TPTC_IDX_ID      8'h67
`define TPTC_IDX_STAT    8'h68
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define TPTC_CTRL_EN     0
`define TPTC_CFG_EXTCLK  3
`define TPTC_CFG_TSEL    2
`define TPTC_CFG_INV     1
`define TPTC_CFG_SCROLL  0
`define TPTC_RST_BYTE    8'h00
// ----------------------------------------------------------------
// indirect map locations
// ----------------------------------------------------------------
`define TPTC_IND_HOLD    8'h00
`define TPTC_IND_HTOT_L  8'h01
`define TPTC_IND_HTOT_H  8'h02
`define TPTC_IND_VTOT_L  8'h03
`define TPTC_IND_VTOT_H  8'h04
`define TPTC_IND_HACT_L  8'h05
`define TPTC_IND_HACT_H  8'h06
`define TPTC_IND_VACT_L  8'h07
`define TPTC_IND_VACT_H  8'h08
`define TPTC_IND_HSW     8'h09
`define TPTC_IND_VSW     8'h0A
`define TPTC_IND_HBP     8'h0B
`define TPTC_IND_VBP     8'h0C
`define TPTC_IND_SYNC    8'h0D
`define TPTC_IND_MASK    8'h0E
`define TPTC_IND_SEL     8'h0F
// ----------------------------------------------------------------
// internal divided clock: one pixel every DIV_LAST+1 cycles
// ----------------------------------------------------------------
`define TPTC_DIV_LAST    4'h1
`endif

// file: rtl/tptc_pkg.sv
package tptc_pkg;
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        de;
		logic        hs;
		logic        vs;
		logic [23:0] rgb;
	} tptc_vid_t;

	typedef struct packed {
		logic      pclk;
		tptc_vid_t vid;
	} tptc_pin_t;

	typedef struct packed {
		logic              en;
		logic [7:0]        cfg;
		logic [7:0]        ia;
		logic [255:0][7:0] mem;
		logic              ack;
		logic [31:0]       rdata;
		tptc_pin_t         s1;
		tptc_pin_t         s2;
		logic              pclk_d;
		logic [3:0]        div;
		logic [11:0]       h;
		logic [11:0]       v;
		logic [11:0]       x;
		logic [11:0]       y;
		logic              de_d;
		logic              vs_d;
		logic [2:0]        pat;
		logic [7:0]        frames;
		tptc_vid_t         out;
	} tptc_state_t;
endpackage : tptc_pkg

// file: bench/tptc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module tptc_top_test;
	logic                clk_i = 1'b0;
	logic                sys_rst_i = 1'b1;
	logic [9:0]          avs_address_i = 10'h000;
	logic                avs_read_i = 1'b0;
	logic                avs_write_i = 1'b0;
	logic [31:0]         avs_writedata_i = 32'h00000000;
	logic [3:0]          avs_byteenable_i = 4'hF;
	logic [31:0]         avs_readdata_o;
	logic                avs_waitrequest_o;
	logic                ext_pclk_i = 1'b0;
	tptc_pkg::tptc_vid_t vid_i = '0;
	tptc_pkg::tptc_vid_t vid_o;
	logic                pattern_active_o;
	logic [2:0]          current_pattern_o;
	int                  failures = 0;
	int                  n_checks = 0;
	logic                pclk_run = 1'b0;
	logic [1:0]          pdiv = 2'h0;
	logic                cnt_on = 1'b0;
	logic                mon = 1'b0;
	int                  de_cnt, hs_cnt, vs_cnt, wh_cnt, chg;
	logic [2:0]          prevp;
	logic [31:0]         seed = 32'h30D35E68;
	logic [7:0]          exp_mem [256];
	logic [31:0]         rd;
	logic [7:0]          a;

	tptc_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .ext_pclk_i(ext_pclk_i),
		.vid_i(vid_i), .vid_o(vid_o), .pattern_active_o(pattern_active_o),
		.current_pattern_o(current_pattern_o));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [23:0] color(input logic [2:0] p);
		case (p)
			3'h1: return 24'hFFFFFF;
			3'h2: return 24'h000000;
			3'h3: return 24'hFF0000;
			3'h4: return 24'h00FF00;
			default: return 24'h0000FF;
		endcase
	endfunction : color

	function automatic logic [2:0] nxt(input logic [2:0] p);
		return (p == 3'h3) ? 3'h1 : p + 3'h1;
	endfunction : nxt

	task automatic complete_run;
		if (failures == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [7:0] idx,
			input logic [7:0] d, output logic [31:0] q);
		int i;
		@(posedge clk_i);
		avs_address_i <= {idx, 2'b00};
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_writedata_i <= {24'h000000, d};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (i == 20) begin
			failures++;
			complete_run();
		end
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask : wr

	task automatic ind_wr(input logic [7:0] ad, input logic [7:0] d);
		wr(8'h66, ad);
		wr(8'h67, d);
	endtask : ind_wr

	// ------------------------------------------------------------
	// pixel clock source and monitors
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (pclk_run) begin
			pdiv <= (pdiv == 2'h2) ? 2'h0 : pdiv + 2'h1;
			if (pdiv == 2'h2) ext_pclk_i <= ~ext_pclk_i;
		end
	end

	always @(posedge clk_i) begin
		if (cnt_on) begin
			if (vid_o.de === 1'b1) de_cnt++;
			if (vid_o.hs === 1'b1) hs_cnt++;
			if (vid_o.vs === 1'b1) vs_cnt++;
			if (vid_o.rgb === 24'hFFFFFF) wh_cnt++;
		end
		if (mon && current_pattern_o !== prevp) begin
			chg++;
			check("scroll step", {29'h0, current_pattern_o}, {29'h0, nxt(prevp)});
			prevp = current_pattern_o;
		end
	end

	task automatic count_win(input int n);
		de_cnt = 0;
		hs_cnt = 0;
		vs_cnt = 0;
		wh_cnt = 0;
		cnt_on <= 1'b1;
		repeat (n) @(posedge clk_i);
		cnt_on <= 1'b0;
		@(posedge clk_i);
	endtask : count_win

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int r = 8'h64; r <= 8'h67; r++) begin
			bus(1'b0, r[7:0], 8'h00, rd);
			check("reset value", rd, 32'h0);
		end
		// random indirect traffic above the timing locations
		for (int i = 0; i < 256; i++) exp_mem[i] = 8'h00;
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			a = (seed[7:0] < 8'h10) ? seed[7:0] + 8'h10 : seed[7:0];
			ind_wr(a, seed[15:8]);
			exp_mem[a] = seed[15:8];
			bus(1'b0, 8'h66, 8'h00, rd);
			check("indirect address", rd, {24'h0, a});
		end
		for (int i = 16; i < 256; i += 7) begin
			wr(8'h66, i[7:0]);
			bus(1'b0, 8'h67, 8'h00, rd);
			check("indirect data", rd, {24'h0, exp_mem[i]});
		end
		wr(8'h66, a);
		avs_byteenable_i <= 4'hE;
		wr(8'h67, 8'hA5);
		avs_byteenable_i <= 4'hF;
		bus(1'b0, 8'h67, 8'h00, rd);
		check("masked write", rd, {24'h0, exp_mem[a]});
		bus(1'b0, 8'h3C, 8'h00, rd);
		check("unmapped read", rd, 32'h0);
		// second reset clears the indirect space
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		wr(8'h66, a);
		bus(1'b0, 8'h67, 8'h00, rd);
		check("indirect after reset", rd, 32'h0);
		// external timing: pass-through, solid patterns, invert
		seed = lfsr(seed);
		vid_i <= {3'b100, seed[23:0]};
		pclk_run <= 1'b1;
		repeat (60) @(posedge clk_i);
		check("pass video", {8'h0, vid_o.rgb}, {8'h0, seed[23:0]});
		check("insert off", {31'h0, pattern_active_o}, 32'h0);
		wr(8'h64, 8'h01);
		for (int p = 1; p <= 5; p++) begin
			for (int inv = 0; inv < 2; inv++) begin
				ind_wr(8'h0F, p[7:0]);
				wr(8'h65, inv[0] ? 8'h02 : 8'h00);
				repeat (60) @(posedge clk_i);
				check("pattern colour", {8'h0, vid_o.rgb},
					{8'h0, color(p[2:0]) ^ {24{inv[0]}}});
				check("shown pattern", {29'h0, current_pattern_o}, p);
			end
		end
		// internal timing: 8x6 total, 4x2 active, sync widths 1, porches 1
		ind_wr(8'h01, 8'h08);
		ind_wr(8'h03, 8'h06);
		ind_wr(8'h05, 8'h04);
		ind_wr(8'h07, 8'h02);
		for (int r = 8'h09; r <= 8'h0C; r++) ind_wr(r[7:0], 8'h01);
		pclk_run <= 1'b0;
		wr(8'h65, 8'h04);
		repeat (200) @(posedge clk_i);
		count_win(960);
		check("internal de time", de_cnt, 160);
		check("internal hs time", hs_cnt, 120);
		check("internal vs time", vs_cnt, 160);
		// checker pattern with both sync polarities inverted
		ind_wr(8'h0D, 8'h03);
		ind_wr(8'h0F, 8'h07);
		repeat (20) @(posedge clk_i);
		count_win(960);
		check("inverted hs time", hs_cnt, 840);
		check("inverted vs time", vs_cnt, 800);
		check("checker white", wh_cnt, 80);
		// external clock select stopped: output must freeze
		wr(8'h65, 8'h0C);
		repeat (20) @(posedge clk_i);
		count_win(200);
		check("frozen de", (de_cnt == 0 || de_cnt == 200), 1);
		pclk_run <= 1'b1;
		repeat (400) @(posedge clk_i);
		count_win(2880);
		check("ext clock de time", de_cnt, 480);
		// auto scroll through patterns 1..3, two frames each
		pclk_run <= 1'b0;
		ind_wr(8'h00, 8'h02);
		ind_wr(8'h0E, 8'h0E);
		ind_wr(8'h0F, 8'h01);
		wr(8'h65, 8'h05);
		repeat (300) @(posedge clk_i);
		prevp = current_pattern_o;
		chg = 0;
		mon <= 1'b1;
		repeat (1920) @(posedge clk_i);
		mon <= 1'b0;
		@(posedge clk_i);
		check("scroll steps", chg, 10);
		wr(8'h65, 8'h04);
		repeat (300) @(posedge clk_i);
		prevp = current_pattern_o;
		check("held pattern", {29'h0, prevp}, 32'h1);
		chg = 0;
		repeat (960) @(posedge clk_i);
		check("pattern held", {29'h0, current_pattern_o}, {29'h0, prevp});
		wr(8'h64, 8'h00);
		repeat (10) @(posedge clk_i);
		check("insert cleared", {31'h0, pattern_active_o}, 32'h0);
		complete_run();
	end
endmodule : tptc_top_test
`default_nettype wire
